/* File: verilog/pcrs_pkg.sv */
/*
 * Shared constants for the fetch pointer and return stack block.
 * Assumes a single core clock and one binary-encoded operation per cycle from decode.
 */
package pcrs_pkg;
    localparam int ADDR_W = 21;
    localparam int PTR_W = 5;
    localparam int DBG_PTR_W = 6;
    localparam int DEPTH = 31;
    localparam int DBG_DEPTH = 35;
    localparam int UPPER_W = 5;
    localparam int HIGH_LSB = 8;
    localparam int HIGH_MSB = 15;
    localparam int UPPER_LSB = 16;
    localparam int UPPER_MSB = 20;
    localparam logic [20:0] ADDR_ZERO = 21'h000000;
    localparam logic [20:0] STEP = 21'h000002;
    localparam logic [20:0] MEM_TOP_DEFAULT = 21'h007FFF;
    localparam logic [7:0] LOW_LSB_MASK = 8'hFE;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [4:0] UPPER_ZERO = 5'h00;
    localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;
    localparam logic [7:0] STATUS_RESTORE_MASK = 8'hE7;
    localparam logic [5:0] PTR_ZERO = 6'h00;
    localparam logic [5:0] PTR_ONE = 6'h01;

    typedef enum logic [3:0] {
        PCRS_OP_NONE,
        PCRS_OP_SEQ,
        PCRS_OP_JUMP,
        PCRS_OP_CALL,
        PCRS_OP_IRQ,
        PCRS_OP_RETURN,
        PCRS_OP_SW_PUSH,
        PCRS_OP_SW_POP
    } pcrs_op_t;
endpackage : pcrs_pkg

/* File: verilog/pcrs_shadow.sv */
/*
 * One-level shadow of status, working and bank-select registers.
 * Assumes the core applies restore values in the cycle restore_o is high.
 */
`timescale 1ns/100ps
module pcrs_shadow (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic save_i,
    input wire logic restore_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] working_register_i,
    input wire logic [7:0] bank_select_register_i,
    output logic restore_o,
    output logic [7:0] status_o,
    output logic [7:0] working_register_o,
    output logic [7:0] bank_select_register_o
);
    logic [7:0] stat_r, stat_nxt;
    logic [7:0] work_r, work_nxt;
    logic [7:0] bank_r, bank_nxt;

    always_comb begin
        stat_nxt = stat_r;
        work_nxt = work_r;
        bank_nxt = bank_r;
        if (save_i) begin
            stat_nxt = status_i;
            work_nxt = working_register_i;
            bank_nxt = bank_select_register_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_r <= pcrs_pkg::BYTE_ZERO;
            work_r <= pcrs_pkg::BYTE_ZERO;
            bank_r <= pcrs_pkg::BYTE_ZERO;
        end else begin
            stat_r <= stat_nxt;
            work_r <= work_nxt;
            bank_r <= bank_nxt;
        end
    end

    // Timeout and power-down bits pass through from the live status.
    assign status_o = (stat_r & pcrs_pkg::STATUS_RESTORE_MASK)
        | (status_i & pcrs_pkg::STATUS_KEEP_MASK);
    assign working_register_o = work_r;
    assign bank_select_register_o = bank_r;
    assign restore_o = restore_i;
endmodule : pcrs_shadow

/* File: verilog/pcrs_core.sv */
/*
 * Fetch pointer, latches and return address stack of the core.
 * Assumes decode gives one operation per cycle on op_i and that software
 * accesses arrive as one-cycle strobes from the same clock domain.
 */
`timescale 1ns/100ps
// How it works
// - Fetch address is 21 bits in low, high and upper bytes.
// - Only the low byte is directly readable and writable by software.
// - Writing the low byte loads high and upper bytes from latches.
// - Reading the low byte copies high and upper bytes into latches.
// - Bit zero stays zero; sequential fetch adds two.
// - Calls, jumps and branches load the address directly, ignoring latches.
// - Calls and interrupts push, returns pop; latches stay unchanged.
// - Stack holds 31 entries, or 35 with six-bit pointer in debug mode.
// - Push increments pointer first, then writes next address.
// - Pop reads the addressed entry, then decrements the pointer.
// - Pointer resets to zero; slot zero has no storage.
// - Top-entry registers access only the currently addressed entry.
// - Software reads and writes the pointer, range 0 to 31, or 0 to 63 in debug mode.
// - Full flag sets on the 32nd push without a pop, or the 36th in debug mode.
// - With fault reset enabled, overflow resets device and zeroes pointer.
// - Without it, pointer stays 31 (35 in debug mode) and further pushes overwrite that entry.
// - Software writing the full flag never requests a reset.
// - Empty pop returns zero, sets flag, resets if enabled.
// - Flags clear only by software write or power-on reset.
// - Software push stores current address; software pop only decrements.
// - Interrupt saves status, working, bank; fast return restores most.
// - Fast call saves and fast return restores the shadow registers.
// - Addresses beyond implemented memory read back as all zeros.
module pcrs_core #(
    parameter logic [20:0] MEM_TOP = pcrs_pkg::MEM_TOP_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire pcrs_pkg::pcrs_op_t op_i,
    input wire logic fast_i,
    input wire logic [20:0] target_i,
    input wire logic stack_fault_reset_enable_i,
    input wire logic in_circuit_debug_mode_i,
    input wire logic low_wr_i,
    input wire logic low_rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic high_latch_wr_i,
    input wire logic upper_latch_wr_i,
    input wire logic ptr_wr_i,
    input wire logic top_low_wr_i,
    input wire logic top_high_wr_i,
    input wire logic top_upper_wr_i,
    input wire logic full_flag_wr_i,
    input wire logic empty_flag_wr_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] working_register_i,
    input wire logic [7:0] bank_select_register_i,
    input wire logic [15:0] mem_rdata_i,
    output logic [20:0] fetch_addr_o,
    output logic [15:0] instr_o,
    output logic [7:0] fetch_addr_low_byte_o,
    output logic [7:0] high_byte_latch_o,
    output logic [4:0] upper_byte_latch_o,
    output logic [5:0] return_stack_pointer_o,
    output logic [20:0] top_entry_o,
    output logic stack_full_flag_o,
    output logic stack_empty_pop_flag_o,
    output logic stack_reset_req_o,
    output logic restore_o,
    output logic [7:0] status_o,
    output logic [7:0] working_register_o,
    output logic [7:0] bank_select_register_o
);
    localparam int AW = pcrs_pkg::ADDR_W;

    logic [AW-1:0] stack_mem [1:pcrs_pkg::DBG_DEPTH];
    logic [AW-1:0] pc_r, pc_nxt;
    logic [7:0] hlat_r, hlat_nxt;
    logic [4:0] ulat_r, ulat_nxt;
    logic [5:0] sp_r, sp_nxt;
    logic ovf_r, ovf_nxt;
    logic unf_r, unf_nxt;
    logic rst_req_r, rst_req_nxt;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [AW-1:0] wr_val;
    logic [5:0] max_ptr;
    logic [AW-1:0] top_val;
    logic push;
    logic pop;
    logic save;

    // Debug mode widens the pointer to reach the extra debugger entries.
    assign max_ptr = in_circuit_debug_mode_i ? 6'(pcrs_pkg::DBG_DEPTH)
                                             : 6'(pcrs_pkg::DEPTH);
    assign top_val = (sp_r == pcrs_pkg::PTR_ZERO) ? pcrs_pkg::ADDR_ZERO
                                                  : stack_mem[sp_r];
    assign push = (op_i == pcrs_pkg::PCRS_OP_CALL)
               || (op_i == pcrs_pkg::PCRS_OP_IRQ)
               || (op_i == pcrs_pkg::PCRS_OP_SW_PUSH);
    assign pop = (op_i == pcrs_pkg::PCRS_OP_RETURN);
    assign save = (op_i == pcrs_pkg::PCRS_OP_IRQ)
               || (op_i == pcrs_pkg::PCRS_OP_CALL && fast_i);

    always_comb begin
        pc_nxt = pc_r;
        hlat_nxt = hlat_r;
        ulat_nxt = ulat_r;
        sp_nxt = sp_r;
        ovf_nxt = ovf_r;
        unf_nxt = unf_r;
        rst_req_nxt = 1'b0;
        wr_en = 1'b0;
        wr_idx = sp_r;
        wr_val = pc_r;
        case (op_i)
            pcrs_pkg::PCRS_OP_SEQ: begin
                pc_nxt = pc_r + pcrs_pkg::STEP;
            end
            pcrs_pkg::PCRS_OP_JUMP: begin
                pc_nxt = target_i;
            end
            pcrs_pkg::PCRS_OP_CALL, pcrs_pkg::PCRS_OP_IRQ,
            pcrs_pkg::PCRS_OP_SW_PUSH: begin
                if (sp_r >= max_ptr) begin
                    ovf_nxt = 1'b1;
                    if (stack_fault_reset_enable_i) begin
                        rst_req_nxt = 1'b1;
                        sp_nxt = pcrs_pkg::PTR_ZERO;
                    end else begin
                        wr_en = 1'b1;
                        wr_idx = max_ptr;
                    end
                end else begin
                    sp_nxt = sp_r + pcrs_pkg::PTR_ONE;
                    wr_en = 1'b1;
                    wr_idx = sp_nxt;
                end
                if (op_i != pcrs_pkg::PCRS_OP_SW_PUSH) begin
                    pc_nxt = target_i;
                end
            end
            pcrs_pkg::PCRS_OP_RETURN: begin
                if (sp_r == pcrs_pkg::PTR_ZERO) begin
                    pc_nxt = pcrs_pkg::ADDR_ZERO;
                    unf_nxt = 1'b1;
                    rst_req_nxt = stack_fault_reset_enable_i;
                end else begin
                    pc_nxt = top_val;
                    sp_nxt = sp_r - pcrs_pkg::PTR_ONE;
                end
            end
            pcrs_pkg::PCRS_OP_SW_POP: begin
                if (sp_r != pcrs_pkg::PTR_ZERO) begin
                    sp_nxt = sp_r - pcrs_pkg::PTR_ONE;
                end
            end
            default: begin
            end
        endcase
        // Software top-entry writes act after any push in the same cycle.
        if (top_low_wr_i || top_high_wr_i || top_upper_wr_i) begin
            if (sp_nxt != pcrs_pkg::PTR_ZERO) begin
                wr_idx = sp_nxt;
                wr_val = wr_en ? pc_r : stack_mem[sp_nxt];
                wr_en = 1'b1;
                if (top_low_wr_i) begin
                    wr_val[7:0] = wdata_i;
                end
                if (top_high_wr_i) begin
                    wr_val[pcrs_pkg::HIGH_MSB:pcrs_pkg::HIGH_LSB] = wdata_i;
                end
                if (top_upper_wr_i) begin
                    wr_val[pcrs_pkg::UPPER_MSB:pcrs_pkg::UPPER_LSB] =
                        wdata_i[pcrs_pkg::UPPER_W-1:0];
                end
            end
        end
        if (ptr_wr_i) begin
            sp_nxt = wdata_i[5:0];
            if (!in_circuit_debug_mode_i) begin
                sp_nxt[5] = 1'b0;
            end
        end
        if (low_wr_i) begin
            pc_nxt = {ulat_r, hlat_r,
                      wdata_i & pcrs_pkg::LOW_LSB_MASK};
        end
        if (high_latch_wr_i) begin
            hlat_nxt = wdata_i;
        end
        if (upper_latch_wr_i) begin
            ulat_nxt = wdata_i[pcrs_pkg::UPPER_W-1:0];
        end
        if (low_rd_i) begin
            hlat_nxt = pc_r[pcrs_pkg::HIGH_MSB:pcrs_pkg::HIGH_LSB];
            ulat_nxt = pc_r[pcrs_pkg::UPPER_MSB:pcrs_pkg::UPPER_LSB];
        end
        // Hardware set outranks a software clear in the same cycle.
        if (full_flag_wr_i && !(push && sp_r >= max_ptr)) begin
            ovf_nxt = wdata_i[0];
        end
        if (empty_flag_wr_i && !(pop && sp_r == pcrs_pkg::PTR_ZERO)) begin
            unf_nxt = wdata_i[1];
        end
        pc_nxt[0] = 1'b0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (wr_en) begin
            stack_mem[wr_idx] <= wr_val;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r <= pcrs_pkg::ADDR_ZERO;
            hlat_r <= pcrs_pkg::BYTE_ZERO;
            ulat_r <= pcrs_pkg::UPPER_ZERO;
            sp_r <= pcrs_pkg::PTR_ZERO;
            rst_req_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            hlat_r <= hlat_nxt;
            ulat_r <= ulat_nxt;
            sp_r <= sp_nxt;
            rst_req_r <= rst_req_nxt;
        end
    end

    // Flags survive ordinary resets, including the one they request.
    always_ff @(posedge ref_clk_i or posedge por_i) begin
        if (por_i) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
            unf_r <= unf_nxt;
        end
    end

    pcrs_shadow u_shadow (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .save_i(save),
        .restore_i(pop && fast_i),
        .status_i(status_i),
        .working_register_i(working_register_i),
        .bank_select_register_i(bank_select_register_i),
        .restore_o(restore_o),
        .status_o(status_o),
        .working_register_o(working_register_o),
        .bank_select_register_o(bank_select_register_o)
    );

    assign fetch_addr_o = pc_r;
    // Unimplemented space fetches as zero, which decodes as no-operation.
    assign instr_o = (pc_r > MEM_TOP) ? 16'h0000 : mem_rdata_i;
    assign fetch_addr_low_byte_o = pc_r[7:0];
    assign high_byte_latch_o = hlat_r;
    assign upper_byte_latch_o = ulat_r;
    assign return_stack_pointer_o = sp_r;
    assign top_entry_o = top_val;
    assign stack_full_flag_o = ovf_r;
    assign stack_empty_pop_flag_o = unf_r;
    assign stack_reset_req_o = rst_req_r;
endmodule : pcrs_core

/* File: bench/pcrs_mem_model.sv */
/*
 * Program memory model on the far side of the fetch port.
 * Assumes a zero-wait memory addressed by the core's fetch address.
 */
`timescale 1ns/100ps
module pcrs_mem_model (
    input wire logic [20:0] addr_i,
    output logic [15:0] rdata_o
);
    // Every word is nonzero, so zeroing above the top shows.
    assign rdata_o = {addr_i[15:1], 1'b1} ^ 16'hA500;
endmodule : pcrs_mem_model

/* File: bench/pcrs_checker.sv */
/*
 * Concurrent checks on the fetch pointer and return stack core.
 * Assumes the bench never mixes top-entry writes with a call.
 */
`timescale 1ns/100ps
module pcrs_checker #(
    parameter logic [20:0] MEM_TOP = pcrs_pkg::MEM_TOP_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire pcrs_pkg::pcrs_op_t op_i,
    input wire logic fast_i,
    input wire logic [20:0] target_i,
    input wire logic stack_fault_reset_enable_i,
    input wire logic in_circuit_debug_mode_i,
    input wire logic low_wr_i,
    input wire logic low_rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic ptr_wr_i,
    input wire logic [15:0] mem_rdata_i,
    input wire logic [20:0] fetch_addr_o,
    input wire logic [15:0] instr_o,
    input wire logic [7:0] high_byte_latch_o,
    input wire logic [4:0] upper_byte_latch_o,
    input wire logic [5:0] return_stack_pointer_o,
    input wire logic [20:0] top_entry_o,
    input wire logic stack_full_flag_o,
    input wire logic stack_empty_pop_flag_o,
    input wire logic stack_reset_req_o,
    input wire logic restore_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Software overrides win over the op, so they are kept out here.
    wire calm = !low_wr_i && !ptr_wr_i && !in_circuit_debug_mode_i;
    wire [5:0] sp = return_stack_pointer_o;
    wire en = stack_fault_reset_enable_i;
    wire is_call = op_i == pcrs_pkg::PCRS_OP_CALL;
    wire is_ret = op_i == pcrs_pkg::PCRS_OP_RETURN;
    AST_SEQ: assert property (op_i == pcrs_pkg::PCRS_OP_SEQ && calm
        |=> fetch_addr_o == $past(fetch_addr_o) + 21'h000002)
        else $error("sequential step wrong");
    AST_JUMP: assert property (op_i == pcrs_pkg::PCRS_OP_JUMP && calm
        |=> fetch_addr_o[20:1] == $past(target_i[20:1]))
        else $error("jump target not loaded");
    AST_LOW_WR: assert property (low_wr_i |=> fetch_addr_o ==
        {$past(upper_byte_latch_o), $past(high_byte_latch_o),
        $past(wdata_i) & 8'hFE}) else $error("low write load wrong");
    AST_LOW_RD: assert property (low_rd_i |=>
        {upper_byte_latch_o, high_byte_latch_o} == $past(fetch_addr_o[20:8]))
        else $error("low read copy wrong");
    AST_PUSH: assert property (is_call && calm && sp < 6'h1F
        |=> sp == $past(sp) + 6'h01 && top_entry_o == $past(fetch_addr_o))
        else $error("push wrong");
    AST_POP: assert property (is_ret && calm && sp != 6'h00
        |=> fetch_addr_o == $past(top_entry_o) && sp == $past(sp) - 6'h01)
        else $error("pop wrong");
    AST_UNDERFLOW: assert property (is_ret && calm && sp == 6'h00
        && !por_i |=> fetch_addr_o == 21'h000000 && stack_empty_pop_flag_o)
        else $error("empty pop wrong");
    AST_OVF_RESET: assert property (is_call && calm && sp == 6'h1F
        && en |=> (sp == 6'h00 && stack_full_flag_o) ##[0:1] stack_reset_req_o)
        else $error("overflow reset wrong");
    AST_OVF_HOLD: assert property (is_call && calm && sp == 6'h1F
        && !en |=> sp == 6'h1F && stack_full_flag_o && !stack_reset_req_o
        && top_entry_o == $past(fetch_addr_o)) else $error("overflow hold");
    AST_EMPTY_SLOT: assert property (sp == 6'h00
        |-> top_entry_o == 21'h000000) else $error("slot zero not empty");
    AST_MEM_TOP: assert property (instr_o ==
        (fetch_addr_o > MEM_TOP ? 16'h0000 : mem_rdata_i))
        else $error("fetch data wrong");
    AST_RESTORE: assert property (restore_o == (is_ret && fast_i))
        else $error("restore strobe wrong");
    cover property (is_call && calm && sp == 6'h1F && !en);
    cover property (is_ret && calm && sp == 6'h00 && en);
    cover property (restore_o);
endmodule : pcrs_checker

bind pcrs_core pcrs_checker #(.MEM_TOP(MEM_TOP)) u_chk (.*);

/* File: bench/tb.sv */
/*
 * Self-checking bench for the fetch pointer and return stack core.
 * Assumes the package, core, memory model and checker are compiled first.
 */
`timescale 1ns/100ps
module tb;
    localparam pcrs_pkg::pcrs_op_t C_SEQ = pcrs_pkg::PCRS_OP_SEQ;
    localparam pcrs_pkg::pcrs_op_t C_CALL = pcrs_pkg::PCRS_OP_CALL;
    localparam pcrs_pkg::pcrs_op_t C_RET = pcrs_pkg::PCRS_OP_RETURN;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, fast_i = 1'b0;
    pcrs_pkg::pcrs_op_t op_i = pcrs_pkg::PCRS_OP_NONE;
    logic [20:0] target_i = 21'h000000;
    logic stack_fault_reset_enable_i = 1'b1, in_circuit_debug_mode_i = 1'b0;
    logic low_wr_i = 1'b0, low_rd_i = 1'b0, high_latch_wr_i = 1'b0;
    logic upper_latch_wr_i = 1'b0, ptr_wr_i = 1'b0, top_low_wr_i = 1'b0;
    logic top_high_wr_i = 1'b0, top_upper_wr_i = 1'b0;
    logic full_flag_wr_i = 1'b0, empty_flag_wr_i = 1'b0;
    logic [7:0] wdata_i = 8'h00, status_i = 8'h00;
    logic [7:0] working_register_i = 8'h00, bank_select_register_i = 8'h00;
    logic [15:0] mem_rdata_i, instr_o;
    logic [20:0] fetch_addr_o, top_entry_o;
    logic [7:0] fetch_addr_low_byte_o, high_byte_latch_o, status_o;
    logic [7:0] working_register_o, bank_select_register_o;
    logic [4:0] upper_byte_latch_o;
    logic [5:0] return_stack_pointer_o;
    logic stack_full_flag_o, stack_empty_pop_flag_o, stack_reset_req_o;
    logic restore_o, seen;
    int n_mismatch = 0, n_checks = 0, cyc = 0;

    pcrs_core dut (.*);
    pcrs_mem_model mem (.addr_i(fetch_addr_o), .rdata_o(mem_rdata_i));

    always #12.5 ref_clk_i = ~ref_clk_i;

    // The whole run needs well under a thousand cycles.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Entered at a falling edge; strobes last exactly one rising edge.
    task automatic go(input pcrs_pkg::pcrs_op_t o = pcrs_pkg::PCRS_OP_NONE,
                      input logic [20:0] t = 21'h000000);
        op_i = o;
        target_i = t;
        @(negedge ref_clk_i);
        op_i = pcrs_pkg::PCRS_OP_NONE;
        {low_wr_i, low_rd_i, high_latch_wr_i, upper_latch_wr_i} = 4'h0;
        {ptr_wr_i, top_low_wr_i, top_high_wr_i, top_upper_wr_i} = 4'h0;
        {full_flag_wr_i, empty_flag_wr_i, fast_i} = 3'h0;
    endtask : go

    task automatic rst();
        rst_i = 1'b1;
        go();
        rst_i = 1'b0;
    endtask : rst

    task automatic t_fetch();
        chk(top_entry_o, 24'h0);
        go(C_SEQ);
        go(C_SEQ);
        chk(fetch_addr_o, 24'h4);
        wdata_i = 8'h12;
        high_latch_wr_i = 1'b1;
        go();
        wdata_i = 8'h03;
        upper_latch_wr_i = 1'b1;
        go();
        wdata_i = 8'h35;
        low_wr_i = 1'b1;
        go();
        chk(fetch_addr_o, 24'h031234);
        chk(fetch_addr_low_byte_o, 24'h34);
        chk(instr_o, 24'h0);
        go(pcrs_pkg::PCRS_OP_JUMP, 21'h000100);
        chk(instr_o, 24'hA401);
        chk({upper_byte_latch_o, high_byte_latch_o}, 24'h0312);
        low_rd_i = 1'b1;
        go();
        chk({upper_byte_latch_o, high_byte_latch_o}, 24'h0001);
        $display("fetch test done");
    endtask : t_fetch

    task automatic t_calls();
        status_i = 8'hFF;
        working_register_i = 8'hA5;
        bank_select_register_i = 8'h3C;
        fast_i = 1'b1;
        go(C_CALL, 21'h000400);
        chk(return_stack_pointer_o, 24'h1);
        chk(top_entry_o, 24'h000100);
        status_i = 8'h00;
        working_register_i = 8'h00;
        bank_select_register_i = 8'h00;
        op_i = C_RET;
        fast_i = 1'b1;
        #1;
        chk(restore_o, 24'h1);
        chk({status_o, working_register_o, bank_select_register_o},
            24'hE7A53C);
        go(C_RET);
        chk(fetch_addr_o, 24'h000100);
        status_i = 8'h81;
        working_register_i = 8'h11;
        bank_select_register_i = 8'h22;
        go(pcrs_pkg::PCRS_OP_IRQ, 21'h000008);
        chk(top_entry_o, 24'h000100);
        status_i = 8'h18;
        op_i = C_RET;
        fast_i = 1'b1;
        #1;
        chk({status_o, working_register_o, bank_select_register_o},
            24'h991122);
        go(C_RET);
        chk(return_stack_pointer_o, 24'h0);
        chk({upper_byte_latch_o, high_byte_latch_o}, 24'h0001);
        $display("call test done");
    endtask : t_calls

    task automatic t_overflow();
        repeat (31) go(C_CALL, 21'h000100);
        chk(stack_full_flag_o, 24'h0);
        go(C_CALL, 21'h000100);
        chk(return_stack_pointer_o, 24'h0);
        chk(stack_full_flag_o, 24'h1);
        seen = stack_reset_req_o;
        go();
        chk(seen | stack_reset_req_o, 24'h1);
        full_flag_wr_i = 1'b1;
        wdata_i = 8'h00;
        go();
        chk(stack_full_flag_o, 24'h0);
        full_flag_wr_i = 1'b1;
        wdata_i = 8'h01;
        go();
        go();
        chk({stack_reset_req_o, stack_full_flag_o}, 24'h1);
        rst();
        chk(stack_full_flag_o, 24'h1);
        full_flag_wr_i = 1'b1;
        wdata_i = 8'h00;
        go();
        stack_fault_reset_enable_i = 1'b0;
        repeat (31) go(C_CALL, 21'h000010);
        chk(stack_full_flag_o, 24'h0);
        go(C_SEQ);
        go(C_CALL, 21'h000010);
        chk(return_stack_pointer_o, 24'h1F);
        chk(top_entry_o, 24'h000012);
        chk({stack_full_flag_o, stack_reset_req_o}, 24'h2);
        rst();
        go(C_RET);
        chk(stack_empty_pop_flag_o, 24'h1);
        stack_fault_reset_enable_i = 1'b1;
        go(C_RET);
        chk(stack_reset_req_o, 24'h1);
        go();
        chk(stack_reset_req_o, 24'h0);
        full_flag_wr_i = 1'b1;
        empty_flag_wr_i = 1'b1;
        wdata_i = 8'h00;
        go();
        chk({stack_full_flag_o, stack_empty_pop_flag_o}, 24'h0);
        rst();
        in_circuit_debug_mode_i = 1'b1;
        repeat (33) go(C_CALL, 21'h000020);
        chk({stack_full_flag_o, return_stack_pointer_o}, 24'h21);
        in_circuit_debug_mode_i = 1'b0;
        $display("overflow test done");
    endtask : t_overflow

    task automatic t_soft();
        // No interrupt is raised while software edits the stack.
        rst();
        wdata_i = 8'h03;
        ptr_wr_i = 1'b1;
        go(pcrs_pkg::PCRS_OP_JUMP, 21'h000200);
        chk(return_stack_pointer_o, 24'h3);
        wdata_i = 8'h56;
        top_low_wr_i = 1'b1;
        go();
        wdata_i = 8'h34;
        top_high_wr_i = 1'b1;
        go();
        wdata_i = 8'h12;
        top_upper_wr_i = 1'b1;
        go();
        chk(top_entry_o, 24'h123456);
        go(pcrs_pkg::PCRS_OP_SW_PUSH);
        chk(top_entry_o, 24'h000200);
        go(pcrs_pkg::PCRS_OP_SW_POP);
        chk(top_entry_o, 24'h123456);
        wdata_i = 8'h77;
        top_low_wr_i = 1'b1;
        go(pcrs_pkg::PCRS_OP_SW_PUSH);
        chk(top_entry_o, 24'h000277);
        $display("software stack test done");
    endtask : t_soft

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    initial begin
        repeat (12) @(negedge ref_clk_i);
        rst_i = 1'b0;
        por_i = 1'b0;
        t_fetch();
        t_calls();
        t_overflow();
        t_soft();
        close_out();
    end
endmodule : tb
